// ### logic/aac_alu.sv
/*
  Eight-bit combinational arithmetic and logic unit.
  Assumes the caller selects operands and decides which flags to keep.
*/
module aac_alu import aac_pkg::*; (
  // Operation
  input wire aac_alu_op_t op,
  input wire logic carryIn,
  // Operands
  input wire logic [DATA_W-1:0] opA,
  input wire logic [DATA_W-1:0] opB,
  // Results
  output logic [DATA_W-1:0] result,
  output logic carryOut,
  output logic nibbleOut,
  output logic nullOut
);
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    result = 8'h00;
    carryOut = carryIn;
    case (op)
      ALU_PASS_A: result = opA;
      ALU_PASS_B: result = opB;
      ALU_ZERO: result = 8'h00;
      ALU_ADD: begin
        sum = {1'b0, opB} + {1'b0, opA};
        nib = {1'b0, opB[3:0]} + {1'b0, opA[3:0]};
        result = sum[7:0];
        carryOut = sum[8];
      end
      ALU_SUB: begin
        // Two's complement: carry out high means no borrow
        sum = {1'b0, opB} + {1'b0, ~opA} + 9'h001;
        nib = {1'b0, opB[3:0]} + {1'b0, ~opA[3:0]} + 5'h01;
        result = sum[7:0];
        carryOut = sum[8];
      end
      ALU_INC: result = opB + 8'h01;
      ALU_DEC: result = opB - 8'h01;
      ALU_OR: result = opA | opB;
      ALU_AND: result = opA & opB;
      ALU_XOR: result = opA ^ opB;
      ALU_COM: result = ~opB;
      ALU_RR: begin
        result = {carryIn, opB[7:1]};
        carryOut = opB[0];
      end
      ALU_RL: begin
        result = {opB[6:0], carryIn};
        carryOut = opB[7];
      end
      ALU_SWAP: result = {opB[3:0], opB[7:4]};
      default: result = 8'h00;
    endcase
  end

  assign nibbleOut = nib[4];
  assign nullOut = (result == 8'h00);
endmodule // aac_alu

// ### logic/aac_core.sv
/*
  Execution core: four-phase instruction cycle, two-stage fetch/execute,
  accumulator, mapped control locations and the general register file.
  Assumes a synchronous program memory on clk_sys that presents the word
  at progAddr within three clocks.
*/
module aac_core import aac_pkg::*; #(
  parameter int PC_W = 9,
  parameter int FILE_DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Program memory bus
  output logic [PC_W-1:0] progAddr,
  input wire logic [INSTR_W-1:0] progData,
  // Observation
  output logic [DATA_W-1:0] accumOut,
  output logic [DATA_W-1:0] statusOut
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  aac_phase_t phaseQ, phaseD;
  logic [PC_W-1:0] pcQ, pcD;
  logic [INSTR_W-1:0] instrQ, instrD;
  logic [DATA_W-1:0] accQ, accD;
  logic [DATA_W-1:0] statusQ, statusD;
  logic [DATA_W-1:0] fsrQ, fsrD;
  logic [DATA_W-1:0] operandQ, operandD;

  always_comb begin
    case (phaseQ)
      PH_ONE: phaseD = PH_TWO;
      PH_TWO: phaseD = PH_THREE;
      PH_THREE: phaseD = PH_FOUR;
      PH_FOUR: phaseD = PH_ONE;
      default: phaseD = PH_ONE;
    endcase
  end

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic fmtByte, fmtBit, fmtLit, isGoto, destSel;
  logic [3:0] byteCode;
  logic [1:0] bitCode;
  logic [4:0] fileField, effAddr;
  logic [2:0] bitIdx;
  logic [7:0] literal, bitMask;
  logic [PC_W-1:0] gotoTarget;

  assign fmtByte = (instrQ[11:10] == FMT_BYTE);
  assign fmtBit = (instrQ[11:10] == FMT_BIT);
  assign fmtLit = (instrQ[11:10] == FMT_LIT);
  assign isGoto = (instrQ[11:9] == GOTO_CODE);
  assign byteCode = instrQ[9:6];
  assign bitCode = instrQ[9:8];
  assign destSel = instrQ[5];
  assign fileField = instrQ[4:0];
  assign bitIdx = instrQ[7:5];
  assign literal = instrQ[7:0];
  assign bitMask = 8'h01 << bitIdx;
  assign gotoTarget = PC_W'(instrQ[8:0]);
  // Indirect location resolves through the pointer register
  assign effAddr = (fileField == ADDR_INDIRECT) ? fsrQ[4:0] : fileField;

  // ---------------------------------------------------------------
  // Operation decode
  // ---------------------------------------------------------------
  aac_alu_op_t aluOp;
  logic useLit, wrFile, wrAcc, affC, affNib, affZ, skipZero;
  logic [7:0] opA;

  always_comb begin
    aluOp = ALU_PASS_B;
    useLit = 1'b0;
    wrFile = 1'b0;
    wrAcc = 1'b0;
    affC = 1'b0;
    affNib = 1'b0;
    affZ = 1'b0;
    skipZero = 1'b0;
    opA = accQ;
    if (fmtByte) begin
      case (byteCode)
        BOP_MOVE: begin
          aluOp = ALU_PASS_A;
          wrFile = destSel;
        end
        BOP_CLEAR: begin
          aluOp = ALU_ZERO;
          wrFile = destSel;
          wrAcc = ~destSel;
          affZ = 1'b1;
        end
        BOP_SUB: begin
          aluOp = ALU_SUB;
          affC = 1'b1;
          affNib = 1'b1;
          affZ = 1'b1;
        end
        BOP_ADD: begin
          aluOp = ALU_ADD;
          affC = 1'b1;
          affNib = 1'b1;
          affZ = 1'b1;
        end
        BOP_DEC: begin
          aluOp = ALU_DEC;
          affZ = 1'b1;
        end
        BOP_INC: begin
          aluOp = ALU_INC;
          affZ = 1'b1;
        end
        BOP_OR: begin
          aluOp = ALU_OR;
          affZ = 1'b1;
        end
        BOP_AND: begin
          aluOp = ALU_AND;
          affZ = 1'b1;
        end
        BOP_XOR: begin
          aluOp = ALU_XOR;
          affZ = 1'b1;
        end
        BOP_PASS: begin
          aluOp = ALU_PASS_B;
          affZ = 1'b1;
        end
        BOP_COM: begin
          aluOp = ALU_COM;
          affZ = 1'b1;
        end
        BOP_RR: begin
          aluOp = ALU_RR;
          affC = 1'b1;
        end
        BOP_RL: begin
          aluOp = ALU_RL;
          affC = 1'b1;
        end
        BOP_SWAP: aluOp = ALU_SWAP;
        BOP_DEC_SKIP: begin
          aluOp = ALU_DEC;
          skipZero = 1'b1;
        end
        BOP_INC_SKIP: begin
          aluOp = ALU_INC;
          skipZero = 1'b1;
        end
        default: aluOp = ALU_PASS_B;
      endcase
      // Result goes back to the location or to the accumulator
      if (byteCode > BOP_CLEAR) begin
        wrFile = destSel;
        wrAcc = ~destSel;
      end
    end else if (fmtBit) begin
      if (!bitCode[1]) begin
        aluOp = bitCode[0] ? ALU_OR : ALU_AND;
        opA = bitCode[0] ? bitMask : ~bitMask;
        wrFile = 1'b1;
      end
    end else if (fmtLit) begin
      useLit = 1'b1;
      wrAcc = 1'b1;
      affZ = (bitCode != 2'h0);
      case (bitCode)
        2'h0: aluOp = ALU_PASS_B;
        2'h1: aluOp = ALU_OR;
        2'h2: aluOp = ALU_AND;
        2'h3: aluOp = ALU_XOR;
        default: aluOp = ALU_PASS_B;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Operand read and arithmetic
  // ---------------------------------------------------------------
  logic rdEn, isGpr, exec, fileWr, memWrEn, fptrWr, testBit, skipTaken, flush, isSub;
  logic [7:0] memData, mappedData, fileData, opB, aluResult;
  logic aluCarry, aluNibble, aluNull;

  assign rdEn = (phaseQ == PH_TWO);
  assign exec = (phaseQ == PH_FOUR);
  assign isGpr = (effAddr >= ADDR_GPR_BASE);
  // Control locations read like any other location
  assign mappedData = (effAddr == ADDR_FPTR) ? pcQ[7:0] :
                      (effAddr == ADDR_STATUS) ? statusQ :
                      (effAddr == ADDR_FSR) ? fsrQ : 8'h00;
  assign fileData = isGpr ? memData : mappedData;
  assign operandD = (phaseQ == PH_THREE) ? fileData : operandQ;
  assign opB = useLit ? literal : operandQ;
  assign isSub = (aluOp == ALU_SUB);

  aac_regfile #(.DEPTH(FILE_DEPTH), .AW(FILE_AW), .DW(DATA_W)) u_regfile (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rdEn(rdEn),
    .rdAddr(effAddr),
    .rdData(memData),
    .wrEn(memWrEn),
    .wrAddr(effAddr),
    .wrData(aluResult)
  );

  aac_alu u_alu (
    .op(aluOp),
    .carryIn(statusQ[ST_CARRY]),
    .opA(opA),
    .opB(opB),
    .result(aluResult),
    .carryOut(aluCarry),
    .nibbleOut(aluNibble),
    .nullOut(aluNull)
  );

  // ---------------------------------------------------------------
  // Write-back and flow
  // ---------------------------------------------------------------
  assign fileWr = exec & wrFile;
  assign memWrEn = fileWr & isGpr;
  assign fptrWr = fileWr & (effAddr == ADDR_FPTR);
  assign testBit = operandQ[bitIdx];
  assign skipTaken = (fmtBit & bitCode[1] & (bitCode[0] ? testBit : ~testBit)) | (skipZero & aluNull);
  // Any flow change throws away the word fetched meanwhile
  assign flush = isGoto | fptrWr | skipTaken;

  // Pointer advances with the fetch so reset starts at location zero
  assign pcD = !exec ? pcQ :
               isGoto ? gotoTarget :
               fptrWr ? PC_W'(aluResult) : PC_W'(pcQ + 1'b1);
  assign instrD = !exec ? instrQ : (flush ? NOP_INSTR : progData);
  assign accD = (exec & wrAcc) ? aluResult : accQ;
  assign fsrD = (fileWr & (effAddr == ADDR_FSR)) ? aluResult : fsrQ;

  // Flag updates win over a plain write of the status location
  always_comb begin
    statusD = statusQ;
    if (fileWr && (effAddr == ADDR_STATUS)) begin
      statusD = aluResult;
    end
    if (exec) begin
      if (affC) begin
        statusD[ST_CARRY] = aluCarry;
      end
      if (affNib) begin
        statusD[ST_NIBBLE] = aluNibble;
      end
      if (affZ) begin
        statusD[ST_NULL] = aluNull;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phaseQ <= PH_ONE;
      pcQ <= '0;
      instrQ <= NOP_INSTR;
      accQ <= ACC_RST;
      statusQ <= STATUS_RST;
      fsrQ <= FSR_RST;
      operandQ <= 8'h00;
    end else begin
      phaseQ <= phaseD;
      pcQ <= pcD;
      instrQ <= instrD;
      accQ <= accD;
      statusQ <= statusD;
      fsrQ <= fsrD;
      operandQ <= operandD;
    end
  end

  assign progAddr = pcQ;
  assign accumOut = accQ;
  assign statusOut = statusQ;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_cycle_len: assert property (phaseQ == PH_ONE |-> ##4 phaseQ == PH_ONE)
    else $error("instruction cycle is not four clocks");
  a_fetch_load: assert property (exec && !flush |=> instrQ == $past(progData))
    else $error("prefetched word not loaded");
  a_pc_step: assert property (exec && !isGoto && !fptrWr |=> pcQ == PC_W'($past(pcQ) + 1'b1))
    else $error("fetch pointer did not advance by one");
  a_flush_nop: assert property (exec && flush |=> instrQ == NOP_INSTR ##3 instrQ == NOP_INSTR)
    else $error("discarded word was executed");
  a_goto_dest: assert property (exec && isGoto |=> pcQ == $past(gotoTarget))
    else $error("jump target not taken");
  a_null_flag: assert property (exec && affZ |=> statusQ[ST_NULL] == ($past(aluResult) == 8'h00))
    else $error("null flag wrong");
  a_sub_borrow: assert property (exec && isSub |=> statusQ[ST_CARRY] == ($past(operandQ) >= $past(accQ)))
    else $error("subtract carry polarity wrong");
  a_sub_nibble: assert property (exec && isSub |=> statusQ[ST_NIBBLE] == ($past(operandQ[3:0]) >= $past(accQ[3:0])))
    else $error("subtract nibble borrow wrong");
  a_acc_write: assert property ($changed(accQ) |-> $past(exec) && $past(wrAcc))
    else $error("accumulator changed without an accumulator write");
  a_ptr_write: assert property ($changed(fsrQ) |-> $past(phaseQ) == PH_FOUR)
    else $error("location written outside the fourth phase");

  c_goto: cover property (exec && isGoto);
  c_skip: cover property (exec && skipTaken);
  c_sub_borrow: cover property (exec && isSub && !aluCarry);
  c_fptr_write: cover property (fptrWr);
endmodule // aac_core

// ### logic/aac_pkg.sv
/*
  Shared constants and types for the accumulator ALU core: instruction fields,
  data-space map, status bit positions, reset values and phase timing.
  Assumes a single core clock and a program memory outside the core.
*/
package aac_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int INSTR_CYCLE_NS = CLK_PERIOD_NS * PHASES_PER_CYCLE;

  // ---------------------------------------------------------------
  // Data-space map
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] ADDR_FPTR = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_FSR = 5'h04;
  localparam logic [4:0] ADDR_GPR_BASE = 5'h08;

  // ---------------------------------------------------------------
  // Status bits and reset values
  // ---------------------------------------------------------------
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_NULL = 2;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] FSR_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [11:0] NOP_INSTR = 12'h000;

  // ---------------------------------------------------------------
  // Instruction classes and codes
  // ---------------------------------------------------------------
  localparam logic [1:0] FMT_BYTE = 2'h0;
  localparam logic [1:0] FMT_BIT = 2'h1;
  localparam logic [1:0] FMT_LIT = 2'h3;
  localparam logic [2:0] GOTO_CODE = 3'h5;
  localparam logic [3:0] BOP_MOVE = 4'h0;
  localparam logic [3:0] BOP_CLEAR = 4'h1;
  localparam logic [3:0] BOP_SUB = 4'h2;
  localparam logic [3:0] BOP_DEC = 4'h3;
  localparam logic [3:0] BOP_OR = 4'h4;
  localparam logic [3:0] BOP_AND = 4'h5;
  localparam logic [3:0] BOP_XOR = 4'h6;
  localparam logic [3:0] BOP_ADD = 4'h7;
  localparam logic [3:0] BOP_PASS = 4'h8;
  localparam logic [3:0] BOP_COM = 4'h9;
  localparam logic [3:0] BOP_INC = 4'hA;
  localparam logic [3:0] BOP_DEC_SKIP = 4'hB;
  localparam logic [3:0] BOP_RR = 4'hC;
  localparam logic [3:0] BOP_RL = 4'hD;
  localparam logic [3:0] BOP_SWAP = 4'hE;
  localparam logic [3:0] BOP_INC_SKIP = 4'hF;

  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} aac_phase_t;
  typedef enum logic [3:0] {
    ALU_PASS_A, ALU_PASS_B, ALU_ZERO, ALU_ADD, ALU_SUB, ALU_INC, ALU_DEC,
    ALU_OR, ALU_AND, ALU_XOR, ALU_COM, ALU_RR, ALU_RL, ALU_SWAP
  } aac_alu_op_t;
endpackage

// ### logic/aac_regfile.sv
/*
  General-purpose data registers: one registered read port, one write port.
  Assumes the caller keeps mapped control locations out of the write path.
*/
module aac_regfile #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Read port
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData
);
  // No reset on the array: contents are undefined after power-up
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule // aac_regfile

// ### test/aac_prog_mem.sv
/*
  Program memory model for the accumulator ALU core: 512 words of 12 bits.
  Assumes the bench fills the word array before the core leaves reset.
*/
module aac_prog_mem import aac_pkg::*; #(
  parameter int AW = 9
) (
  // Clock
  input wire logic clk_sys,
  // Fetch bus
  input wire logic [AW-1:0] progAddr,
  output logic [INSTR_W-1:0] progData
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [INSTR_W-1:0] wordMem [0:(1<<AW)-1];
  logic [AW-1:0] lastAddr = '0;

  initial progData = 12'h000;

  // Whole word on its own bus, one per fetch
  // Right after an address change the word is not yet valid: show a changing value
  always @(posedge clk_sys) begin
    if (progAddr != lastAddr) begin
      progData <= ~progData;
    end else begin
      progData <= wordMem[progAddr];
    end
    lastAddr <= progAddr;
  end
endmodule // aac_prog_mem

// ### test/accumulator_alu_core_tb.sv
/*
  Self-checking bench for the accumulator ALU core with an instruction-level model.
  Assumes the program memory model answers within the fetch contract of the core.
*/
module accumulator_alu_core_tb import aac_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PCW = 9;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [PCW-1:0] progAddr;
  logic [INSTR_W-1:0] progData;
  logic [DATA_W-1:0] accumOut;
  logic [DATA_W-1:0] statusOut;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 32'hf177_36cf;
  int cycles = 0;
  int mAcc, mSt, mFsr, mPc, mIr;
  int mReg [0:31];
  int progImg [0:511];

  aac_core #(.PC_W(PCW), .FILE_DEPTH(32)) aac_core_i (
    .clk_sys(clk_sys), .resetn(resetn), .progAddr(progAddr), .progData(progData),
    .accumOut(accumOut), .statusOut(statusOut));
  aac_prog_mem #(.AW(PCW)) aac_prog_mem_i (
    .clk_sys(clk_sys), .progAddr(progAddr), .progData(progData));

  initial forever #12.5 clk_sys = ~clk_sys;

  // A run takes about 4000 clocks, well short of this ceiling of 10000; a hang ends here
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [PCW-1:0] got, input logic [PCW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Instruction-level model
  // ---------------------------------------------------------------
  function automatic int rd(int a);
    case (a)
      0: return (mFsr & 31) == 0 ? 0 : rd(mFsr & 31);
      2: return mPc & 255;
      3: return mSt;
      4: return mFsr;
      1, 5, 6, 7: return 0;
      default: return mReg[a];
    endcase
  endfunction

  function automatic bit wr(int a, int v);
    case (a)
      0: return (mFsr & 31) == 0 ? 1'b0 : wr(mFsr & 31, v);
      2: begin
        mPc = v & 255;
        return 1'b1;
      end
      3: mSt = v & 255;
      4: mFsr = v & 255;
      1, 5, 6, 7: ;
      default: mReg[a] = v & 255;
    endcase
    return 1'b0;
  endfunction

  task automatic step();
    int op, f, c, fv, r, msk, val;
    bit jmp, skp;
    op = mIr;
    f = op & 31;
    c = (op >> 6) & 15;
    fv = rd(f);
    msk = 0;
    val = 0;
    jmp = 0;
    skp = 0;
    if (op[11:10] == 2'b00 && op[9:5] != 0) begin
      case (c)
        0: r = mAcc;
        1: r = 0;
        2: r = fv - mAcc;
        3, 11: r = fv - 1;
        4: r = fv | mAcc;
        5: r = fv & mAcc;
        6: r = fv ^ mAcc;
        7: r = fv + mAcc;
        8: r = fv;
        9: r = ~fv;
        10, 15: r = fv + 1;
        12: r = (fv >> 1) | ((mSt & 1) << 7);
        13: r = (fv << 1) | (mSt & 1);
        default: r = (fv << 4) | (fv >> 4);
      endcase
      r = r & 255;
      if (c == 2) begin
        msk = 3;
        val = (fv >= mAcc ? 1 : 0) + ((fv & 15) >= (mAcc & 15) ? 2 : 0);
      end
      if (c == 7) begin
        msk = 3;
        val = (fv + mAcc > 255 ? 1 : 0) + ((fv & 15) + (mAcc & 15) > 15 ? 2 : 0);
      end
      if (c == 12 || c == 13) begin
        msk = 1;
        val = (c == 12) ? (fv & 1) : (fv >> 7);
      end
      if (c >= 1 && c <= 10) begin
        msk = msk | 4;
        val = val | (r == 0 ? 4 : 0);
      end
      if (op[5]) jmp = wr(f, r);
      else mAcc = r;
      // Flag update wins over a write of the status location
      mSt = (mSt & ~msk) | val;
      skp = (c == 11 || c == 15) && r == 0;
    end else if (op[11:10] == 2'b01) begin
      case (op[9:8])
        0: jmp = wr(f, fv & ~(1 << op[7:5]));
        1: jmp = wr(f, fv | (1 << op[7:5]));
        2: skp = ((fv >> op[7:5]) & 1) == 0;
        default: skp = ((fv >> op[7:5]) & 1) == 1;
      endcase
    end else if (op[11:10] == 2'b11) begin
      case (op[9:8])
        0: mAcc = op & 255;
        1: mAcc = (mAcc | op) & 255;
        2: mAcc = mAcc & op & 255;
        default: mAcc = (mAcc ^ op) & 255;
      endcase
      if (op[9:8] != 0) mSt = (mSt & ~4) | (mAcc == 0 ? 4 : 0);
    end else if (op[11:9] == 3'b101) begin
      mPc = op & 511;
      jmp = 1;
    end
    // A taken jump or skip throws the prefetched word away
    if (jmp) mIr = 0;
    else begin
      mIr = skp ? 0 : progImg[mPc];
      mPc = (mPc + 1) & 511;
    end
  endtask

  task automatic reset_model();
    mAcc = 0;
    mSt = 0;
    mFsr = 0;
    mPc = 0;
    mIr = 0;
  endtask

  // Random instruction; the fetch pointer location is only read, FSR left alone
  function automatic int gen_instr();
    int cls, c, f, d;
    cls = {$random(seed)} % 16;
    f = {$random(seed)} % 32;
    d = {$random(seed)} % 2;
    c = {$random(seed)} % 16;
    if (f == 4) f = 5;
    if (cls < 8) begin
      if (f == 2) d = 0;
      if (c == 0 && f == 2) c = 8;
      else if (c == 0) d = 1;
      return (c << 6) | (d << 5) | f;
    end
    if (cls < 11) return 12'h400 | ($random(seed) & 12'h3E0) | (f == 2 ? 3 : f);
    if (cls < 15) return 12'hC00 | ($random(seed) & 12'h3FF);
    return 12'hA00 | ($random(seed) & 12'h1FF);
  endfunction

  // Each instruction cycle: outputs stand for three clocks, then take the new values
  task automatic run(int n);
    repeat (n) begin
      for (int q = 1; q <= 4; q++) begin
        @(negedge clk_sys);
        if (q == 4) step();
        chk_addr(progAddr, mPc[PCW-1:0]);
        chk_data(accumOut, mAcc[7:0]);
        chk_data(statusOut, mSt[7:0]);
      end
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 512; i++) progImg[i] = gen_instr();
    // Preset every general register, then point FSR at one of them
    for (int i = 8; i < 32; i++) begin
      progImg[2 * i - 16] = 12'hC00 | ($random(seed) & 255);
      progImg[2 * i - 15] = 12'h020 | i;
    end
    progImg[48] = 12'hC0C;
    progImg[49] = 12'h024;
    // Write the fetch pointer location: a jump to 40h that drops the prefetched word
    progImg[50] = 12'hC40;
    progImg[51] = 12'h022;
    // Array filled in zero time so that reset spans only the first eight clocks
    for (int i = 0; i < 512; i++) aac_prog_mem_i.wordMem[i] = 12'(progImg[i]);
    repeat (8) @(negedge clk_sys);
    reset_model();
    resetn = 1'b1;
    run(700);
    repeat (2) @(negedge clk_sys);
    resetn = 1'b0;
    @(negedge clk_sys);
    chk_addr(progAddr, 9'h000);
    chk_data(accumOut, 8'h00);
    chk_data(statusOut, 8'h00);
    @(negedge clk_sys);
    reset_model();
    resetn = 1'b1;
    run(300);
    report_and_stop();
  end
endmodule // accumulator_alu_core_tb
